// ==== src/bus_retry_fault_sequencer.sv ====
// Bus controller: retry, double fault halt and access ordering
`timescale 1ns/1ps
module bus_retry_fault_sequencer
  import bus_seq_pkg::*;
#(
  parameter int WQ_N = WQ_DEPTH
)(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Read requests from the operand fetch stage
  input wire logic rd_req,
  input wire logic [ADDR_W-1:0] rd_addr,
  input wire logic [ATTR_W-1:0] rd_attr,
  input wire logic rd_serialized,
  input wire logic rd_line,
  input wire logic rd_burst,
  input wire logic rd_locked,
  output logic rd_ready,
  output logic rd_done,
  // Write requests from write-back
  input wire logic wr_req,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic wr_serialized,
  input wire logic wr_locked_last,
  input wire logic wr_cache_hit,
  output logic wr_ready,
  output logic cache_update,
  // Push cancel and exception context
  input wire logic cur_is_push,
  input wire logic push_snoop_kill,
  input wire logic in_exc_stacking,
  input wire logic sync_no_op,
  output logic sync_stall,
  output logic bus_error,
  // External bus
  input wire logic transfer_ack,
  input wire logic transfer_error_ack,
  input wire logic bus_grant_in,
  output logic bus_request_out,
  output logic [ADDR_W-1:0] bus_addr_out,
  output logic [ATTR_W-1:0] bus_attr_out,
  output logic bus_write_out,
  output logic transfer_start,
  output logic locked_sequence,
  output logic locked_sequence_end,
  output logic bus_out_en,
  output logic [3:0] processor_status_code
);
  bus_state_t state_reg, state_next;
  logic [ADDR_W-1:0] addr_reg;
  logic [ATTR_W-1:0] attr_reg;
  logic wr_reg, line_reg, burst_reg, lock_reg, locked_sequence_end_reg, push_reg;
  logic [1:0] beat_reg;
  logic start_reg;
  logic wq_pop;
  logic [ADDR_W-1:0] wq_head;
  logic wq_hit, wq_empty, wq_full;
  logic cyc_wr_is_queued;

  ////////////////////////////////////////////////////////////
  // Pending writes
  wire wr_take = wr_req && !wq_full && state_reg != ST_HALT;
  assign wr_ready = !wq_full && state_reg != ST_HALT;
  // Cache line updated on hit without waiting for the bus
  assign cache_update = wr_take && wr_cache_hit;

  write_queue #(.DEPTH(WQ_N), .AW(ADDR_W)) u_wq (
    .core_clk(core_clk),
    .rst(rst),
    .push(wr_take),
    .push_addr(wr_addr),
    .pop(wq_pop),
    .head_addr(wq_head),
    .probe_addr(rd_addr),
    .probe_hit(wq_hit),
    .empty(wq_empty),
    .full(wq_full)
  );

  ////////////////////////////////////////////////////////////
  // Termination decode
  wire active = state_reg == ST_ACTIVE;
  wire term_retry = active && transfer_ack && transfer_error_ack;
  wire term_err = active && !transfer_ack && transfer_error_ack;
  wire term_ok = active && transfer_ack && !transfer_error_ack;
  wire later_beat = line_reg && beat_reg != BEAT_FIRST;
  // Retry past the first line beat degrades to an error
  wire retry_abort = term_retry && later_beat;
  wire retry_again = term_retry && !later_beat;
  wire cyc_err = term_err || retry_abort;
  wire line_more = term_ok && line_reg && beat_reg != BEATS_LAST;
  wire cyc_end = (term_ok && !line_more) || cyc_err;
  // Only errors during stacking escalate; handler errors do not
  wire dbl_fault = cyc_err && in_exc_stacking;

  ////////////////////////////////////////////////////////////
  // Request selection: reads first unless ordering forbids
  // Serialized read drains all writes; colliding read drains the hit
  wire rd_blocked = (rd_serialized && !wq_empty) || wq_hit;
  wire rd_go = rd_req && !rd_blocked;
  wire wr_go = !wq_empty && !rd_go;
  wire can_start = bus_grant_in;
  wire launch = (state_reg == ST_IDLE) && can_start && (rd_go || wr_go);
  assign rd_ready = launch && rd_go;
  assign wq_pop = cyc_end && cyc_wr_is_queued && !dbl_fault;
  assign cyc_wr_is_queued = wr_reg;

  // Pipeline frozen until writes drain and bus quiet
  assign sync_stall = sync_no_op && (!wq_empty || state_reg != ST_IDLE);

  ////////////////////////////////////////////////////////////
  // State machine
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (launch)
          state_next = ST_ACTIVE;
      ST_ACTIVE:
        if (dbl_fault)
          state_next = ST_HALT;
        else if (term_retry && !bus_grant_in && !retry_abort)
          state_next = ST_RELEASE;
        else if (cyc_end)
          state_next = ST_IDLE;
      // Retry resumes once grant returns unless push_snoop_kill cancels a push, which goes to idle; stored access kept
      ST_RELEASE:
        if (bus_grant_in)
          state_next = push_reg && push_snoop_kill ? ST_IDLE : ST_ACTIVE;
      // No exit except reset
      ST_HALT:
        state_next = ST_HALT;
      default:
        state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  ////////////////////////////////////////////////////////////
  // Access descriptor, held across retries
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      addr_reg <= '0;
      attr_reg <= '0;
      wr_reg <= 1'b0;
      line_reg <= 1'b0;
      burst_reg <= 1'b0;
      push_reg <= 1'b0;
      beat_reg <= BEAT_FIRST;
    end
    else if (launch)
    begin
      addr_reg <= rd_go ? rd_addr : wq_head;
      attr_reg <= rd_go ? rd_attr : '0;
      wr_reg <= !rd_go;
      line_reg <= rd_go && rd_line;
      burst_reg <= rd_go && rd_burst;
      push_reg <= !rd_go && cur_is_push;
      beat_reg <= BEAT_FIRST;
    end
    else if (line_more)
      beat_reg <= beat_reg + 1'b1;
    else if (state_reg == ST_RELEASE && push_reg && push_snoop_kill)
      push_reg <= 1'b0;
  end

  // Lock flags survive retries and drop on a good finish of the locked last write or on any error
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      lock_reg <= 1'b0;
      locked_sequence_end_reg <= 1'b0;
    end
    else if (launch && rd_go && rd_locked)
      lock_reg <= 1'b1;
    else if (launch && !rd_go && wr_locked_last && lock_reg)
      locked_sequence_end_reg <= 1'b1;
    else if ((term_ok && locked_sequence_end_reg) || cyc_err)
    begin
      lock_reg <= 1'b0;
      locked_sequence_end_reg <= 1'b0;
    end
  end

  // Start strobe for first cycle, each retry, immediate or after release, and each further line beat
  always_ff @(posedge core_clk)
  begin
    if (rst)
      start_reg <= 1'b0;
    else
      start_reg <= launch || (retry_again && bus_grant_in) ||
                   (state_reg == ST_RELEASE && state_next == ST_ACTIVE) || line_more;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rd_done <= 1'b0;
      bus_error <= 1'b0;
    end
    else
    begin
      rd_done <= term_ok && !wr_reg && !line_more;
      bus_error <= cyc_err;
    end
  end

  ////////////////////////////////////////////////////////////
  // Pins; halted drops request, output enable, start and lock; address, attr and write stay driven
  wire halted = state_reg == ST_HALT;
  wire owns = (state_reg == ST_ACTIVE) || ((state_reg == ST_IDLE) && bus_grant_in);
  assign bus_out_en = owns && !halted;
  assign bus_request_out = !halted && ((state_reg != ST_IDLE) || rd_req || !wq_empty);
  assign bus_addr_out = addr_reg;
  assign bus_attr_out = attr_reg;
  assign bus_write_out = wr_reg;
  assign transfer_start = start_reg && !halted;
  assign locked_sequence = lock_reg && !halted;
  assign locked_sequence_end = locked_sequence_end_reg && !halted;
  assign processor_status_code = halted ? PST_DOUBLE_FAULT : PST_RUN;

  ////////////////////////////////////////////////////////////
  // Checks
  a_retry_same_addr: assert property (@(posedge core_clk) disable iff (rst)
    retry_again && bus_grant_in |=> addr_reg == $past(addr_reg) && state_reg == ST_ACTIVE)
    else $error("retry changed access");
  a_halt_status: assert property (@(posedge core_clk) disable iff (rst)
    dbl_fault |=> processor_status_code == PST_DOUBLE_FAULT)
    else $error("double fault status missing");
  a_halt_sticky: assert property (@(posedge core_clk) disable iff (rst)
    halted |=> halted)
    else $error("left halt without reset");
  a_halt_release: assert property (@(posedge core_clk) disable iff (rst)
    halted |-> !bus_request_out && !bus_out_en)
    else $error("halted but driving");
  a_retry_no_err: assert property (@(posedge core_clk) disable iff (rst)
    retry_again |=> !bus_error)
    else $error("retry flagged as error");
  a_late_abort: assert property (@(posedge core_clk) disable iff (rst)
    retry_abort |=> bus_error && state_reg != ST_ACTIVE)
    else $error("late line retry not aborted");
  a_serial_wait: assert property (@(posedge core_clk) disable iff (rst)
    rd_ready && rd_serialized |-> wq_empty)
    else $error("serialized read passed writes");
  a_collide_wait: assert property (@(posedge core_clk) disable iff (rst)
    rd_ready |-> !wq_hit)
    else $error("read passed colliding write");
  a_handler_err: assert property (@(posedge core_clk) disable iff (rst)
    cyc_err && !in_exc_stacking |=> !halted)
    else $error("handler error halted");
  a_lock_hold: assert property (@(posedge core_clk) disable iff (rst)
    term_retry && lock_reg && !retry_abort |=> lock_reg)
    else $error("lock dropped on retry");
  a_sync_stall: assert property (@(posedge core_clk) disable iff (rst)
    sync_no_op && !wq_empty |-> sync_stall)
    else $error("sync no-op not stalled");
  c_retry: cover property (@(posedge core_clk) disable iff (rst) retry_again);
  c_relinquish: cover property (@(posedge core_clk) disable iff (rst) state_reg == ST_RELEASE);
  c_halt: cover property (@(posedge core_clk) disable iff (rst) dbl_fault);
  c_line_done: cover property (@(posedge core_clk) disable iff (rst) term_ok && line_reg && beat_reg == BEATS_LAST);
endmodule // bus_retry_fault_sequencer

// ==== src/bus_seq_pkg.sv ====
// Shared constants and types for the bus retry and fault sequencer
package bus_seq_pkg;
  localparam int ADDR_W = 32;
  localparam int ATTR_W = 8;
  localparam int WQ_DEPTH = 4;
  localparam logic [3:0] PST_DOUBLE_FAULT = 4'h5;
  localparam logic [3:0] PST_RUN = 4'h0;
  localparam logic [1:0] BEATS_LAST = 2'h3;
  localparam logic [1:0] BEAT_FIRST = 2'h0;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ACTIVE = 4'b0010,
    ST_RELEASE = 4'b0100,
    ST_HALT = 4'b1000
  } bus_state_t;
endpackage

// ==== src/write_queue.sv ====
// Pending write queue with collision search and registered head
`timescale 1ns/1ps
module write_queue
  import bus_seq_pkg::*;
#(
  parameter int DEPTH = WQ_DEPTH,
  parameter int AW = ADDR_W
)(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Push side
  input wire logic push,
  input wire logic [AW-1:0] push_addr,
  // Pop side
  input wire logic pop,
  output logic [AW-1:0] head_addr,
  // Status
  input wire logic [AW-1:0] probe_addr,
  output logic probe_hit,
  output logic empty,
  output logic full
);
  localparam int PW = $clog2(DEPTH);
  logic [AW-1:0] mem_reg [DEPTH];
  logic [DEPTH-1:0] valid_reg;
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [DEPTH-1:0] hit_vec;
  wire do_push = push && !full;
  wire do_pop = pop && !empty;
  wire [PW-1:0] rd_next = do_pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;

  assign empty = (valid_reg == '0);
  assign full = (valid_reg == '1);
  assign probe_hit = |hit_vec;

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_ent
      assign hit_vec[g] = valid_reg[g] && (mem_reg[g] == probe_addr);
      always_ff @(posedge core_clk)
      begin
        if (rst)
          valid_reg[g] <= 1'b0;
        else if (do_push && wr_ptr_reg == PW'(g))
          valid_reg[g] <= 1'b1;
        else if (do_pop && rd_ptr_reg == PW'(g))
          valid_reg[g] <= 1'b0;
        if (do_push && wr_ptr_reg == PW'(g))
          mem_reg[g] <= push_addr;
      end
    end
  endgenerate

  // Writes leave strictly in arrival order
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      head_addr <= '0;
    end
    else
    begin
      if (do_push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (do_pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      // Bypass: a push into the head slot must be visible next cycle
      head_addr <= (do_push && wr_ptr_reg == rd_next) ? push_addr : mem_reg[rd_next];
    end
  end
endmodule // write_queue

// ==== tb/bus_slave_model.sv ====
// Far-side model: bus slave termination logic and arbiter
`timescale 1ns/1ps
module bus_slave_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Bus from the sequencer
  input wire logic transfer_start,
  // Bench control
  input wire logic cfg_load,
  input wire logic [3:0] cfg_retries,
  input wire logic [2:0] cfg_at,
  input wire logic cfg_err,
  input wire logic cfg_slow,
  input wire logic cfg_grant,
  // Terminations
  output logic transfer_ack = 1'b0,
  output logic transfer_error_ack = 1'b0,
  output logic bus_grant_in
);
  logic st;
  logic [3:0] left_reg;
  logic [2:0] beat_reg;
  logic [1:0] due_reg = 2'h0;
  assign bus_grant_in = cfg_grant;
  always @(posedge core_clk)
  begin
    st = transfer_start;
    #1;
    // Both acks move on the same edge, never apart
    transfer_ack = 1'b0;
    transfer_error_ack = 1'b0;
    if (rst || cfg_load)
    begin
      left_reg = cfg_retries;
      beat_reg = 3'h0;
      st = 1'b0;
      due_reg = 2'h0;
    end
    if (st)
      due_reg = cfg_slow ? 2'h2 : 2'h1;
    if (due_reg == 2'h1)
    begin
      if (left_reg != 4'h0 && beat_reg == cfg_at)
      begin
        transfer_ack = 1'b1;
        transfer_error_ack = 1'b1;
        left_reg = left_reg - 4'h1;
      end
      else
      begin
        transfer_ack = !cfg_err;
        transfer_error_ack = cfg_err;
        beat_reg = beat_reg + 3'h1;
      end
    end
    if (due_reg != 2'h0)
      due_reg = due_reg - 2'h1;
  end
endmodule // bus_slave_model

// ==== tb/tb_top.sv ====
// Self-checking bench for the bus retry and fault sequencer
`timescale 1ns/1ps
module tb_top;
  import bus_seq_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1;
  logic rd_req = 0, rd_serialized = 0, rd_line = 0, rd_burst = 0, rd_locked = 0;
  logic [31:0] rd_addr = 32'h0, wr_addr = 32'h0;
  logic [7:0] rd_attr = 8'h5a;
  logic wr_req = 0, wr_serialized = 0, wr_locked_last = 0, wr_cache_hit = 0;
  logic cur_is_push = 0, push_snoop_kill = 0, in_exc_stacking = 0, sync_no_op = 0;
  logic cfg_load = 0, cfg_err = 0, cfg_slow = 0, cfg_grant = 1;
  logic [3:0] cfg_retries = 4'h0;
  logic [2:0] cfg_at = 3'h0;
  logic rd_ready, rd_done, wr_ready, cache_update, sync_stall, bus_error;
  logic transfer_ack, transfer_error_ack, bus_grant_in, bus_request_out, bus_write_out;
  logic transfer_start, locked_sequence, locked_sequence_end, bus_out_en;
  logic [31:0] bus_addr_out;
  logic [7:0] bus_attr_out;
  logic [3:0] processor_status_code;
  logic [32:0] seen[$];
  int fails = 0, num_checks = 0, ndone = 0, nerr = 0;

  always #10 core_clk = ~core_clk;

  bus_retry_fault_sequencer u_dut (.*);
  bus_slave_model u_far (.core_clk(core_clk), .rst(rst), .transfer_start(transfer_start),
    .cfg_load(cfg_load), .cfg_retries(cfg_retries), .cfg_at(cfg_at), .cfg_err(cfg_err),
    .cfg_slow(cfg_slow), .cfg_grant(cfg_grant), .transfer_ack(transfer_ack),
    .transfer_error_ack(transfer_error_ack), .bus_grant_in(bus_grant_in));

  always @(posedge core_clk)
  begin
    if (transfer_start)
      seen.push_back({bus_write_out, bus_addr_out});
    if (rd_done)
      ndone++;
    if (bus_error)
      nerr++;
  end

  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    num_checks++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cfg(input logic [3:0] r, input logic [2:0] at, input logic e, input logic s);
    seen.delete();
    cfg_retries = r;
    cfg_at = at;
    cfg_err = e;
    cfg_slow = s;
    cfg_load = 1;
    @(posedge core_clk);
    #1 cfg_load = 0;
  endtask

  // Holds the request until rd_ready, then waits for the outcome
  task automatic rd(input logic [31:0] a, input logic ln, input logic bu, input logic se);
    int n = 0;
    ndone = 0;
    nerr = 0;
    {rd_addr, rd_line, rd_burst, rd_serialized, rd_req} = {a, ln, bu, se, 1'b1};
    @(negedge core_clk);
    while (!rd_ready && n++ < 60) @(negedge core_clk);
    chk("rd_accept", 1, rd_ready);
    @(posedge core_clk);
    #1 rd_req = 0;
    while (ndone + nerr == 0 && n++ < 120) @(posedge core_clk);
    chk("rd_end", 1, (ndone + nerr) != 0);
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [31:0] a, input logic hit);
    int n = 0;
    {wr_addr, wr_cache_hit, wr_req} = {a, hit, 1'b1};
    @(negedge core_clk);
    while (!wr_ready && n++ < 20) @(negedge core_clk);
    chk("cache_update", hit, cache_update);
    @(posedge core_clk);
    #1 wr_req = 0;
    @(posedge core_clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////
  // Retries on a plain read, prompt and slow answers
  task automatic t_retry(input logic s);
    cfg(4'h3, 3'h0, 0, s);
    rd(32'h0000_1234, 0, 0, 0);
    chk("starts", 4, seen.size());
    foreach (seen[i]) chk("retry_addr", {1'b0, 32'h0000_1234}, seen[i]);
    chk("attr", 8'h5a, bus_attr_out);
    chk("no_error", 0, nerr);
    chk("done", 1, ndone);
    $display("test retry done");
  endtask

  // Retry position within a line transfer decides rerun or abort
  task automatic t_line(input logic [2:0] at, input logic bu, input int st, input int er);
    cfg(4'h1, at, 0, 0);
    rd(32'h0000_0400, 1, bu, 0);
    chk("line_starts", st, seen.size());
    chk("line_error", er, nerr);
    $display("test line done");
  endtask

  // Reads pass queued writes unless serialized or colliding
  task automatic t_order(input logic se, input logic col);
    logic [31:0] ra = col ? 32'h0000_2004 : 32'h0000_3000;
    cfg(4'h0, 3'h0, 0, 0);
    cfg_grant = 0;
    wr(32'h0000_2000, 1);
    wr(32'h0000_2004, 0);
    sync_no_op = 1;
    @(negedge core_clk);
    chk("stall", 1, sync_stall);
    @(posedge core_clk);
    #1;
    fork
      rd(ra, 0, 0, se);
      #60 cfg_grant = 1;
    join
    repeat (20) @(posedge core_clk);
    #1;
    chk("stall_off", 0, sync_stall);
    sync_no_op = 0;
    chk("order_n", 3, seen.size());
    if (se || col)
    begin
      chk("w0", {1'b1, 32'h0000_2000}, seen[0]);
      chk("w1", {1'b1, 32'h0000_2004}, seen[1]);
      chk("r", {1'b0, ra}, seen[2]);
    end
    else
    begin
      chk("r", {1'b0, ra}, seen[0]);
      chk("w0", {1'b1, 32'h0000_2000}, seen[1]);
      chk("w1", {1'b1, 32'h0000_2004}, seen[2]);
    end
    $display("test order done");
  endtask

  // Error outside and inside stacking; halt lasts until reset
  task automatic t_fault();
    cfg(4'h0, 3'h0, 1, 0);
    rd(32'h0000_0010, 0, 0, 0);
    chk("err", 1, nerr);
    chk("no_halt", PST_RUN, processor_status_code);
    in_exc_stacking = 1;
    rd(32'h0000_0020, 0, 0, 0);
    in_exc_stacking = 0;
    cfg(4'h0, 3'h0, 0, 0);
    {rd_addr, rd_req} = {32'h0000_0030, 1'b1};
    repeat (10)
    begin
      @(negedge core_clk);
      chk("halt_ready", 0, rd_ready);
    end
    chk("halt_code", PST_DOUBLE_FAULT, processor_status_code);
    chk("halt_starts", 0, seen.size());
    chk("halt_req", 0, bus_request_out);
    chk("halt_oe", 0, bus_out_en);
    @(posedge core_clk);
    #1 rst = 1;
    rd_req = 0;
    repeat (3) @(posedge core_clk);
    #1 rst = 0;
    chk("reset_code", PST_RUN, processor_status_code);
    $display("test fault done");
  endtask

  // Locked read then locked last write, each retried once
  task automatic t_lock();
    cfg(4'h1, 3'h0, 0, 0);
    rd_locked = 1;
    rd(32'h0000_0500, 0, 0, 0);
    rd_locked = 0;
    chk("lock_rd_starts", 2, seen.size());
    chk("lock_after_rd", 1, locked_sequence);
    cfg(4'h1, 3'h0, 0, 0);
    wr_locked_last = 1;
    wr(32'h0000_0500, 0);
    repeat (3) @(posedge core_clk);
    #1;
    chk("locked_sequence_end_retry", 1, locked_sequence_end);
    chk("lock_retry", 1, locked_sequence);
    wr_locked_last = 0;
    repeat (4) @(posedge core_clk);
    #1;
    chk("lock_wr_starts", 2, seen.size());
    chk("locked_sequence_end_end", 0, locked_sequence_end);
    chk("lock_end", 0, locked_sequence);
    $display("test lock done");
  endtask

  // Grant taken away with a retry: bus let go, cycle rerun later
  task automatic t_relinquish();
    cfg(4'h1, 3'h0, 0, 0);
    fork
      rd(32'h0000_0600, 0, 0, 0);
      begin
        @(posedge transfer_ack);
        cfg_grant = 0;
        repeat (2) @(posedge core_clk);
        #1;
        chk("release_oe", 0, bus_out_en);
        chk("release_req", 1, bus_request_out);
        cfg_grant = 1;
      end
    join
    chk("rel_starts", 2, seen.size());
    foreach (seen[i]) chk("rel_addr", {1'b0, 32'h0000_0600}, seen[i]);
    chk("rel_done", 1, ndone);
    chk("rel_no_err", 0, nerr);
    $display("test relinquish done");
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge core_clk);
    #1 rst = 0;
    t_retry(0);
    t_retry(1);
    t_line(3'h0, 1, 5, 0);
    t_line(3'h1, 1, 2, 1);
    t_line(3'h2, 0, 3, 1);
    t_order(0, 0);
    t_order(1, 0);
    t_order(0, 1);
    t_lock();
    t_relinquish();
    t_fault();
    test_done();
  end

  initial
  begin
    #100000;
    fails++;
    test_done();
  end
endmodule // tb_top
